// ### fbd_decoder.sv
// fourteen-bit instruction decoder with cycle sequencing
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ns
module fbd_decoder import fbd_pkg::*; (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// instruction and datapath results
	input wire logic [13:0] instr_in,
	input wire logic zero_result_in,
	input wire logic bit_value_in,
	// register port
	input wire logic [1:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// decoded instruction
	output logic [1:0] phase_out,
	output fbd_op_t op_out,
	output logic dest_file_out,
	output logic [6:0] file_addr_out,
	output logic [2:0] bit_pos_out,
	output logic [7:0] literal_out,
	output logic [10:0] target_out,
	output logic [4:0] flag_mask_out,
	output logic pc_change_out,
	output logic nop_cycle_out,
	output logic prescaler_clr_out,
	output logic pin_read_out
);
	// ----------------------------------------
	// opcode decode
	// ----------------------------------------
	function automatic fbd_op_t decode_op(input logic [13:0] ir);
		fbd_op_t op;
		op = NO_OP;
		case (ir[PFX_HI:PFX_LO])
			PFX_BYTE: begin
				// six-bit opcode field, nibble below prefix
				case (ir[NIB_HI:NIB_LO])
					N_MISC: begin
						if (ir[DST_BIT])
							op = ACCUM_STORE_OP;
						else if (ir[LIT_HI:0] == LB_RET)
							op = SUBROUTINE_RETURN;
						else if (ir[LIT_HI:0] == LB_RETI)
							op = INTERRUPT_RETURN;
						else if (ir[LIT_HI:0] == LB_WDT)
							op = WATCHDOG_CLEAR_OP;
						else if (ir[LIT_HI:0] == LB_SLEEP)
							op = STANDBY_ENTER_OP;
						else
							op = NO_OP;
					end
					N_CLR: op = CLEAR_OP;
					N_SUB: op = SUBTRACT_ACCUM_FROM_FILE;
					N_DEC: op = DECREMENT_OP;
					N_IOR: op = INCLUSIVE_OR_FILE;
					N_AND: op = LOGICAL_AND_FILE;
					N_XOR: op = EXCLUSIVE_OR_FILE;
					N_ADD: op = ADD_ACCUM_TO_FILE;
					N_MOV: op = MOVE_FILE_OP;
					N_COM: op = COMPLEMENT_OP;
					N_INC: op = INCREMENT_OP;
					N_DECSZ: op = DECREMENT_SKIP_ZERO;
					N_RROT: op = ROTATE_RIGHT_CARRY;
					N_LROT: op = ROTATE_LEFT_CARRY;
					N_SWAP: op = SWAP_NIBBLE_OP;
					N_INCSZ: op = INCREMENT_SKIP_ZERO;
					default: op = NO_OP;
				endcase
			end
			PFX_BIT: begin
				// two select bits above the bit position
				case (ir[NIB_HI:BSEL_LO])
					B_CLR: op = BIT_CLEAR_OP;
					B_SET: op = BIT_SET_OP;
					B_TSC: op = BIT_TEST_SKIP_CLEAR;
					B_TSS: op = BIT_TEST_SKIP_SET;
					default: op = NO_OP;
				endcase
			end
			PFX_FLOW: begin
				// bit 11 alone splits call from jump; both redirect the pc
				if (ir[JMP_BIT])
					op = JUMP_DIRECT;
				else
					op = SUBROUTINE_CALL;
			end
			PFX_LIT: begin
				// low opcode bits are don't-care in several patterns
				if (ir[NIB_HI:NIB_LO + 2] == LH_LOAD)
					op = LOAD_LITERAL_ACCUM;
				else if (ir[NIB_HI:NIB_LO + 2] == LH_RET)
					op = RETURN_WITH_LITERAL;
				else if (ir[NIB_HI:NIB_LO + 1] == LS_SUB)
					op = SUBTRACT_FROM_LITERAL;
				else if (ir[NIB_HI:NIB_LO + 1] == LS_ADD)
					op = ADD_LITERAL_ACCUM;
				else if (ir[NIB_HI:NIB_LO] == L_IOR)
					op = INCLUSIVE_OR_LITERAL;
				else if (ir[NIB_HI:NIB_LO] == L_AND)
					op = LOGICAL_AND_LITERAL;
				else if (ir[NIB_HI:NIB_LO] == L_XOR)
					op = EXCLUSIVE_OR_LITERAL;
				else
					op = NO_OP;
			end
			// all four prefixes are listed; kept so an unknown word decodes as nop
			default: op = NO_OP;
		endcase
		return op;
	endfunction

	// status flags each operation may change
	// a set mask bit lets the datapath write that flag; the others hold
	function automatic logic [4:0] flags_of(input fbd_op_t op);
		logic [4:0] m;
		m = MSK_NONE;
		case (op)
			ADD_ACCUM_TO_FILE, SUBTRACT_ACCUM_FROM_FILE,
			ADD_LITERAL_ACCUM, SUBTRACT_FROM_LITERAL: m = MSK_CDZ;
			INCLUSIVE_OR_FILE, LOGICAL_AND_FILE, EXCLUSIVE_OR_FILE,
			INCLUSIVE_OR_LITERAL, LOGICAL_AND_LITERAL,
			EXCLUSIVE_OR_LITERAL: m = MSK_Z;
			CLEAR_OP, DECREMENT_OP, MOVE_FILE_OP, COMPLEMENT_OP,
			INCREMENT_OP: m = MSK_Z;
			ROTATE_LEFT_CARRY, ROTATE_RIGHT_CARRY: m = MSK_C;
			WATCHDOG_CLEAR_OP, STANDBY_ENTER_OP: m = MSK_TS;
			default: m = MSK_NONE;
		endcase
		return m;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	fbd_state_t state_reg; // run or inserted nop cycle
	fbd_state_t state_next;
	logic [1:0] phase_reg; // oscillator quarter of the cycle
	// decoded fields, held for a whole instruction cycle
	fbd_op_t op_reg; // operation of the current cycle
	logic dest_reg;
	logic [6:0] faddr_reg;
	logic [2:0] bpos_reg;
	logic [7:0] lit_reg;
	logic [10:0] tgt_reg;
	logic [4:0] mask_reg;
	logic pcchg_reg;
	logic nop_reg;
	logic psclr_reg;
	logic pinrd_reg;
	// software setup and read-only status
	logic [7:0] ctrl_reg; // bit0: prescaler belongs to the timer
	logic [6:0] tmr_addr_reg; // file address of the timer count
	logic [6:0] port_addr_reg; // file address of the i/o port
	logic [5:0] skip_cnt_reg; // taken skips, wraps
	logic [7:0] rdata_reg;

	// ----------------------------------------
	// decode wires
	// ----------------------------------------
	// instr_in is decoded every cycle but only latched at a start edge
	fbd_op_t dec_op;
	logic start; // first quarter: load next instruction
	logic last; // last quarter: decide on a nop cycle
	logic run;
	logic byte_op;
	logic writes_file;
	logic self_mod;
	logic flow_op;
	logic skip_hit;
	logic flush;
	logic [7:0] rsel;

	assign dec_op = decode_op(instr_in);
	assign start = phase_reg == PH_FIRST;
	assign last = phase_reg == PH_LAST;
	assign run = state_reg == RUN_ST;
	assign byte_op = instr_in[PFX_HI:PFX_LO] == PFX_BYTE;
	// byte results go back to the file only with dest set; bit clear and bit set always write it
	assign writes_file = (byte_op && instr_in[NIB_HI:NIB_LO] != N_MISC && instr_in[DST_BIT])
		|| dec_op == ACCUM_STORE_OP || dec_op == BIT_CLEAR_OP
		|| dec_op == BIT_SET_OP;
	// clear and store do not depend on the old value
	assign self_mod = writes_file && dec_op != CLEAR_OP
		&& dec_op != ACCUM_STORE_OP;
	assign flow_op = dec_op == SUBROUTINE_CALL || dec_op == JUMP_DIRECT
		|| dec_op == SUBROUTINE_RETURN || dec_op == INTERRUPT_RETURN
		|| dec_op == RETURN_WITH_LITERAL;
	// datapath results are valid by the last quarter
	assign skip_hit = ((op_reg == DECREMENT_SKIP_ZERO || op_reg == INCREMENT_SKIP_ZERO)
		&& zero_result_in)
		|| (op_reg == BIT_TEST_SKIP_CLEAR && !bit_value_in)
		|| (op_reg == BIT_TEST_SKIP_SET && bit_value_in);
	assign flush = last && (pcchg_reg || skip_hit);
	assign state_next = flush ? FLUSH_ST : (start ? RUN_ST : state_reg);
	assign rsel = (reg_addr_in == REG_CTRL) ? ctrl_reg
		: (reg_addr_in == REG_TMR) ? {1'b0, tmr_addr_reg}
		: (reg_addr_in == REG_PORT) ? {1'b0, port_addr_reg}
		: {skip_cnt_reg, pcchg_reg, nop_reg};

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	// quarter counter and run/flush state
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			phase_reg <= PH_FIRST;
			state_reg <= RUN_ST;
			skip_cnt_reg <= 6'h00;
		end else begin
			phase_reg <= last ? PH_FIRST : phase_reg + 2'h1;
			state_reg <= state_next;
			// count wraps silently: software sees a trend, not a total
			if (last && skip_hit)
				skip_cnt_reg <= skip_cnt_reg + 6'h01;
		end
	end

	// latch fields once per instruction cycle; a flush cycle loads a nop
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			op_reg <= NO_OP;
			dest_reg <= 1'b0;
			faddr_reg <= 7'h00;
			bpos_reg <= 3'h0;
			lit_reg <= 8'h00;
			tgt_reg <= 11'h000;
			mask_reg <= MSK_NONE;
			pcchg_reg <= 1'b0;
			nop_reg <= 1'b0;
			psclr_reg <= 1'b0;
			pinrd_reg <= 1'b0;
		end else if (start) begin
			op_reg <= run ? dec_op : NO_OP;
			dest_reg <= run && instr_in[DST_BIT];
			faddr_reg <= run ? instr_in[FA_HI:0] : 7'h00;
			bpos_reg <= run ? instr_in[BP_HI:BP_LO] : 3'h0;
			lit_reg <= run ? instr_in[LIT_HI:0] : 8'h00;
			tgt_reg <= run ? instr_in[TGT_HI:0] : 11'h000;
			mask_reg <= run ? flags_of(dec_op) : MSK_NONE;
			pcchg_reg <= run && flow_op;
			nop_reg <= !run;
			psclr_reg <= run && writes_file && ctrl_reg[CTRL_PSA_BIT]
				&& instr_in[FA_HI:0] == tmr_addr_reg;
			pinrd_reg <= run && self_mod
				&& instr_in[FA_HI:0] == port_addr_reg;
		end
	end

	// ----------------------------------------
	// register port
	// ----------------------------------------
	// writable setup; status is read only
	// a write lands at the next edge, even mid-instruction; decode uses it from the next start
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_reg <= CTRL_RST;
			tmr_addr_reg <= TMR_ADDR_RST;
			port_addr_reg <= PORT_ADDR_RST;
		end else if (reg_wr_in) begin
			if (reg_addr_in == REG_CTRL)
				ctrl_reg <= reg_wdata_in;
			if (reg_addr_in == REG_TMR)
				tmr_addr_reg <= reg_wdata_in[FA_HI:0];
			if (reg_addr_in == REG_PORT)
				port_addr_reg <= reg_wdata_in[FA_HI:0];
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= reg_rd_in ? rsel : 8'h00;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// every output is a flop straight to the port, no logic after it
	assign reg_rdata_out = rdata_reg;
	assign phase_out = phase_reg;
	assign op_out = op_reg;
	assign dest_file_out = dest_reg;
	assign file_addr_out = faddr_reg;
	assign bit_pos_out = bpos_reg;
	assign literal_out = lit_reg;
	assign target_out = tgt_reg;
	assign flag_mask_out = mask_reg;
	assign pc_change_out = pcchg_reg;
	assign nop_cycle_out = nop_reg;
	assign prescaler_clr_out = psclr_reg;
	assign pin_read_out = pinrd_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// fields are checked one cycle after the start edge that loads them
	// setup registers may change mid-instruction, so decisions are held against $past

	a_byte_fields: assert property (start && run && byte_op
		|=> file_addr_out == $past(instr_in[6:0]) && dest_file_out == $past(instr_in[7]))
		else $error("byte fields wrong");
	a_bit_position: assert property (start && run && instr_in[13:12] == PFX_BIT
		|=> bit_pos_out == $past(instr_in[9:7]) ##1 $stable(bit_pos_out)[*3])
		else $error("bit position wrong");
	a_literal_byte: assert property (start && run && instr_in[13:12] == PFX_LIT
		|=> literal_out == $past(instr_in[7:0]))
		else $error("literal wrong");
	a_jump_nop: assert property (start && run && instr_in[13:12] == PFX_FLOW
		|=> pc_change_out && target_out == $past(instr_in[10:0]) ##4 nop_cycle_out)
		else $error("jump not two cycles");
	a_add_flags: assert property (start && run && byte_op && instr_in[11:8] == 4'h7
		|=> flag_mask_out == 5'h07 && op_out == ADD_ACCUM_TO_FILE)
		else $error("add flags wrong");
	a_and_zero: assert property (start && run && byte_op && instr_in[11:8] == 4'h5
		|=> flag_mask_out == 5'h04)
		else $error("and flags wrong");
	a_rotate_carry: assert property (start && run && byte_op && instr_in[11:9] == 3'h6
		|=> flag_mask_out == 5'h01)
		else $error("rotate flags wrong");
	a_skip_zero: assert property (last && op_out == DECREMENT_SKIP_ZERO && zero_result_in
		|=> start ##1 nop_cycle_out && op_out == NO_OP)
		else $error("zero skip missed");
	a_skip_set: assert property (last && op_out == BIT_TEST_SKIP_SET && !bit_value_in
		|=> ##1 !nop_cycle_out)
		else $error("false skip");
	a_lit_sub: assert property (start && run && instr_in[13:9] == 5'h1e
		|=> op_out == SUBTRACT_FROM_LITERAL && flag_mask_out == 5'h07)
		else $error("literal subtract wrong");
	a_standby_flags: assert property (start && run && instr_in == 14'h0063
		|=> flag_mask_out == 5'h18 && !pc_change_out)
		else $error("standby flags wrong");
	a_nop_quiet: assert property (nop_cycle_out
		|-> op_out == NO_OP && flag_mask_out == 5'h00 && !prescaler_clr_out
		&& !pc_change_out && !dest_file_out && !pin_read_out)
		else $error("nop cycle has effects");
	a_prescaler_clr: assert property (prescaler_clr_out && phase_out == 2'h1
		|-> $past(ctrl_reg[0]) && file_addr_out == $past(tmr_addr_reg) && !nop_cycle_out)
		else $error("bad prescaler clear");
	a_phase_wrap: assert property (last |=> start ##1 phase_out == 2'h1)
		else $error("cycle not four quarters");
	a_dest_accum: assert property (start && run && byte_op && !instr_in[7]
		|=> !dest_file_out && !prescaler_clr_out && !pin_read_out)
		else $error("accumulator destination wrong");
	a_lit_load: assert property (start && run && instr_in[13:10] == 4'hc
		|=> op_out == LOAD_LITERAL_ACCUM && !pc_change_out && flag_mask_out == 5'h00)
		else $error("literal load wrong");
	a_lit_return: assert property (start && run && instr_in[13:10] == 4'hd
		|=> op_out == RETURN_WITH_LITERAL && pc_change_out ##4 nop_cycle_out)
		else $error("literal return not two cycles");
	a_return_flow: assert property (start && run && (instr_in == 14'h0008 || instr_in == 14'h0009)
		|=> pc_change_out && flag_mask_out == 5'h00 ##4 nop_cycle_out)
		else $error("return not two cycles");
	a_lit_or_zero: assert property (start && run && instr_in[13:8] == 6'h38
		|=> op_out == INCLUSIVE_OR_LITERAL && flag_mask_out == 5'h04)
		else $error("literal or wrong");
	a_skip_clear: assert property (last && op_out == BIT_TEST_SKIP_CLEAR && !bit_value_in
		|=> start ##1 nop_cycle_out && op_out == NO_OP)
		else $error("clear-bit skip missed");
	a_pin_read: assert property (pin_read_out && phase_out == 2'h1
		|-> file_addr_out == $past(port_addr_reg) && !nop_cycle_out)
		else $error("bad pin read");

	// main scenarios a test run must reach
	c_skip_taken: cover property (last && skip_hit ##2 nop_cycle_out);
	c_call: cover property (op_out == SUBROUTINE_CALL ##4 nop_cycle_out);
	c_prescaler: cover property (prescaler_clr_out);
	c_pin_read: cover property (pin_read_out);
	c_lit_return: cover property (op_out == RETURN_WITH_LITERAL ##4 nop_cycle_out);
endmodule

// ### fbd_pkg.sv
// constants, types and codes for the fourteen-bit instruction decoder
package fbd_pkg;
	// ----------------------------------------
	// instruction word fields
	// ----------------------------------------
	localparam int PFX_HI = 13;
	localparam int PFX_LO = 12;
	localparam int NIB_HI = 11;
	localparam int NIB_LO = 8;
	localparam int DST_BIT = 7;
	localparam int FA_HI = 6;
	localparam int BP_HI = 9;
	localparam int BP_LO = 7;
	localparam int BSEL_LO = 10;
	localparam int JMP_BIT = 11;
	localparam int TGT_HI = 10;
	localparam int LIT_HI = 7;
	localparam logic [1:0] PFX_BYTE = 2'h0;
	localparam logic [1:0] PFX_BIT = 2'h1;
	localparam logic [1:0] PFX_FLOW = 2'h2;
	localparam logic [1:0] PFX_LIT = 2'h3;
	// ----------------------------------------
	// opcode codes
	// ----------------------------------------
	localparam logic [3:0] N_MISC = 4'h0;
	localparam logic [3:0] N_CLR = 4'h1;
	localparam logic [3:0] N_SUB = 4'h2;
	localparam logic [3:0] N_DEC = 4'h3;
	localparam logic [3:0] N_IOR = 4'h4;
	localparam logic [3:0] N_AND = 4'h5;
	localparam logic [3:0] N_XOR = 4'h6;
	localparam logic [3:0] N_ADD = 4'h7;
	localparam logic [3:0] N_MOV = 4'h8;
	localparam logic [3:0] N_COM = 4'h9;
	localparam logic [3:0] N_INC = 4'ha;
	localparam logic [3:0] N_DECSZ = 4'hb;
	localparam logic [3:0] N_RROT = 4'hc;
	localparam logic [3:0] N_LROT = 4'hd;
	localparam logic [3:0] N_SWAP = 4'he;
	localparam logic [3:0] N_INCSZ = 4'hf;
	localparam logic [1:0] B_CLR = 2'h0;
	localparam logic [1:0] B_SET = 2'h1;
	localparam logic [1:0] B_TSC = 2'h2;
	localparam logic [1:0] B_TSS = 2'h3;
	localparam logic [3:0] L_IOR = 4'h8;
	localparam logic [3:0] L_AND = 4'h9;
	localparam logic [3:0] L_XOR = 4'ha;
	localparam logic [1:0] LH_LOAD = 2'h0;
	localparam logic [1:0] LH_RET = 2'h1;
	localparam logic [2:0] LS_SUB = 3'h6;
	localparam logic [2:0] LS_ADD = 3'h7;
	localparam logic [7:0] LB_RET = 8'h08;
	localparam logic [7:0] LB_RETI = 8'h09;
	localparam logic [7:0] LB_WDT = 8'h64;
	localparam logic [7:0] LB_SLEEP = 8'h63;
	// ----------------------------------------
	// status flag update masks: bit0 C, 1 DC, 2 Z, 3 timeout, 4 sleep
	// ----------------------------------------
	localparam logic [4:0] MSK_NONE = 5'h00;
	localparam logic [4:0] MSK_C = 5'h01;
	localparam logic [4:0] MSK_Z = 5'h04;
	localparam logic [4:0] MSK_CDZ = 5'h07;
	localparam logic [4:0] MSK_TS = 5'h18;
	// ----------------------------------------
	// timing and register map
	// ----------------------------------------
	localparam int PHASES = 4;
	localparam logic [1:0] PH_FIRST = 2'h0;
	localparam logic [1:0] PH_LAST = 2'(PHASES - 1);
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_TMR = 2'h1;
	localparam logic [1:0] REG_PORT = 2'h2;
	localparam logic [1:0] REG_STAT = 2'h3;
	localparam int CTRL_PSA_BIT = 0;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [6:0] TMR_ADDR_RST = 7'h01;
	localparam logic [6:0] PORT_ADDR_RST = 7'h05;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [5:0] {
		NO_OP, ACCUM_STORE_OP, CLEAR_OP, SUBTRACT_ACCUM_FROM_FILE, DECREMENT_OP,
		INCLUSIVE_OR_FILE, LOGICAL_AND_FILE, EXCLUSIVE_OR_FILE, ADD_ACCUM_TO_FILE,
		MOVE_FILE_OP, COMPLEMENT_OP, INCREMENT_OP, DECREMENT_SKIP_ZERO,
		ROTATE_RIGHT_CARRY, ROTATE_LEFT_CARRY, SWAP_NIBBLE_OP, INCREMENT_SKIP_ZERO,
		BIT_CLEAR_OP, BIT_SET_OP, BIT_TEST_SKIP_CLEAR, BIT_TEST_SKIP_SET,
		SUBROUTINE_CALL, JUMP_DIRECT, LOAD_LITERAL_ACCUM, RETURN_WITH_LITERAL,
		INCLUSIVE_OR_LITERAL, LOGICAL_AND_LITERAL, EXCLUSIVE_OR_LITERAL,
		SUBTRACT_FROM_LITERAL, ADD_LITERAL_ACCUM, SUBROUTINE_RETURN,
		INTERRUPT_RETURN, WATCHDOG_CLEAR_OP, STANDBY_ENTER_OP
	} fbd_op_t;
	typedef enum logic {RUN_ST, FLUSH_ST} fbd_state_t;
endpackage

// ### fourteen_bit_instruction_decode_tb.sv
// self-checking testbench for the fourteen-bit instruction decoder
`timescale 1ns/1ns
module fourteen_bit_instruction_decode_tb import fbd_pkg::*;;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic clk_in; // 100 MHz oscillator
	logic rst_in; // async reset, active high
	logic [13:0] instr_in; // word presented for the next start edge
	logic zero_result_in; // datapath zero, sampled at phase 3
	logic bit_value_in; // addressed bit, sampled at phase 3
	logic [1:0] reg_addr_in;
	logic [7:0] reg_wdata_in;
	logic reg_wr_in;
	logic reg_rd_in;
	logic [7:0] reg_rdata_out;
	logic [1:0] phase_out;
	fbd_op_t op_out;
	logic dest_file_out;
	logic [6:0] file_addr_out;
	logic [2:0] bit_pos_out;
	logic [7:0] literal_out;
	logic [10:0] target_out;
	logic [4:0] flag_mask_out;
	logic pc_change_out;
	logic nop_cycle_out;
	logic prescaler_clr_out;
	logic pin_read_out;
	int n_fail; // mismatches seen
	int comparisons; // checks made
	int k; // loop index
	// ----------------------------------------
	// device under test
	// ----------------------------------------
	fbd_decoder u_dut (
		.clk_in(clk_in), .rst_in(rst_in), .instr_in(instr_in),
		.zero_result_in(zero_result_in), .bit_value_in(bit_value_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .phase_out(phase_out),
		.op_out(op_out), .dest_file_out(dest_file_out), .file_addr_out(file_addr_out),
		.bit_pos_out(bit_pos_out), .literal_out(literal_out), .target_out(target_out),
		.flag_mask_out(flag_mask_out), .pc_change_out(pc_change_out),
		.nop_cycle_out(nop_cycle_out), .prescaler_clr_out(prescaler_clr_out),
		.pin_read_out(pin_read_out)
	);
	// ----------------------------------------
	// clock
	// ----------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	// verdict and end of run, the only exit
	task automatic results();
		if (n_fail == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// four-state compare, widened to 16 bits
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask
	// bounded wait until a phase shows after an edge
	task automatic wait_ph(input logic [1:0] p);
		int i;
		for (i = 0; i < 8; i++) begin
			@(posedge clk_in);
			#1;
			if (phase_out === p) break;
		end
		if (i == 8) begin
			n_fail++; // phase counter stuck, give up
			results();
		end
	endtask
	// present a word one cycle ahead of its start edge, then check the decode
	task automatic run(input logic [13:0] w, input logic zr, input logic bv, input fbd_op_t op,
		input logic [4:0] msk, input logic pc, input logic nop);
		wait_ph(2'h3);
		@(posedge clk_in);
		instr_in <= w;
		zero_result_in <= zr; // held through this op's phase 3 edge
		bit_value_in <= bv;
		@(posedge clk_in);
		#1;
		chk(16'(op_out), 16'(op));
		chk(16'(flag_mask_out), 16'(msk));
		chk(16'(pc_change_out), 16'(pc));
		chk(16'(nop_cycle_out), 16'(nop));
	endtask
	// one-cycle write strobe
	task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask
	// one-cycle read strobe; data stands one cycle only, then 0
	task automatic reg_rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1;
		chk(16'(reg_rdata_out), 16'(exp));
		@(posedge clk_in);
		#1;
		chk(16'(reg_rdata_out), 16'h0000);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		n_fail = 0;
		comparisons = 0;
		rst_in = 1'b1;
		instr_in = 14'h0000;
		zero_result_in = 1'b0;
		bit_value_in = 1'b0;
		reg_addr_in = 2'h0;
		reg_wdata_in = 8'h00;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		repeat (6) @(posedge clk_in);
		chk(16'(op_out), 16'(NO_OP));
		rst_in <= 1'b0;
		// phase counts 0..3 from the first start edge
		for (k = 1; k <= 8; k++) begin
			@(posedge clk_in);
			#1;
			chk(16'(phase_out), 16'(k % 4));
		end
		// register resets, read-only status, dropped high bit
		reg_rd(REG_CTRL, CTRL_RST);
		reg_rd(REG_TMR, 8'(TMR_ADDR_RST));
		reg_rd(REG_PORT, 8'(PORT_ADDR_RST));
		reg_wr(REG_STAT, 8'hff);
		reg_rd(REG_STAT, 8'h00);
		reg_wr(REG_TMR, 8'hff);
		reg_rd(REG_TMR, 8'h7f);
		reg_wr(REG_TMR, 8'h01);
		// byte-oriented ops and their fields
		run(14'h07a5, 0, 0, ADD_ACCUM_TO_FILE, MSK_CDZ, 0, 0);
		chk(16'(dest_file_out), 16'h0001);
		chk(16'(file_addr_out), 16'h0025);
		run(14'h0225, 0, 0, SUBTRACT_ACCUM_FROM_FILE, MSK_CDZ, 0, 0);
		chk(16'(dest_file_out), 16'h0000);
		run(14'h0425, 0, 0, INCLUSIVE_OR_FILE, MSK_Z, 0, 0);
		run(14'h0525, 0, 0, LOGICAL_AND_FILE, MSK_Z, 0, 0);
		run(14'h06a5, 0, 0, EXCLUSIVE_OR_FILE, MSK_Z, 0, 0);
		run(14'h0d25, 0, 0, ROTATE_LEFT_CARRY, MSK_C, 0, 0);
		run(14'h0ca5, 0, 0, ROTATE_RIGHT_CARRY, MSK_C, 0, 0);
		run(14'h01a5, 0, 0, CLEAR_OP, MSK_Z, 0, 0);
		run(14'h0925, 0, 0, COMPLEMENT_OP, MSK_Z, 0, 0);
		run(14'h0325, 0, 0, DECREMENT_OP, MSK_Z, 0, 0);
		run(14'h0a25, 0, 0, INCREMENT_OP, MSK_Z, 0, 0);
		run(14'h0825, 0, 0, MOVE_FILE_OP, MSK_Z, 0, 0);
		run(14'h0e25, 0, 0, SWAP_NIBBLE_OP, MSK_NONE, 0, 0);
		run(14'h00a5, 0, 0, ACCUM_STORE_OP, MSK_NONE, 0, 0);
		run(14'h0000, 0, 0, NO_OP, MSK_NONE, 0, 0);
		// skip on zero: taken only when the result is zero
		run(14'h0b25, 0, 0, DECREMENT_SKIP_ZERO, MSK_NONE, 0, 0);
		run(14'h0fa5, 0, 0, INCREMENT_SKIP_ZERO, MSK_NONE, 0, 0);
		run(14'h0b25, 1, 0, DECREMENT_SKIP_ZERO, MSK_NONE, 0, 0);
		run(14'h07a5, 0, 0, NO_OP, MSK_NONE, 0, 1);
		run(14'h0f25, 1, 0, INCREMENT_SKIP_ZERO, MSK_NONE, 0, 0);
		run(14'h07a5, 0, 0, NO_OP, MSK_NONE, 0, 1);
		// bit-oriented ops: position 5, file 0x12
		run(14'h1292, 0, 0, BIT_CLEAR_OP, MSK_NONE, 0, 0);
		chk(16'(bit_pos_out), 16'h0005);
		chk(16'(file_addr_out), 16'h0012);
		run(14'h1692, 0, 0, BIT_SET_OP, MSK_NONE, 0, 0);
		run(14'h1a92, 0, 1, BIT_TEST_SKIP_CLEAR, MSK_NONE, 0, 0);
		run(14'h1a92, 0, 0, BIT_TEST_SKIP_CLEAR, MSK_NONE, 0, 0);
		run(14'h1692, 0, 0, NO_OP, MSK_NONE, 0, 1);
		run(14'h1e92, 0, 0, BIT_TEST_SKIP_SET, MSK_NONE, 0, 0);
		run(14'h1e92, 0, 1, BIT_TEST_SKIP_SET, MSK_NONE, 0, 0);
		run(14'h1692, 0, 0, NO_OP, MSK_NONE, 0, 1);
		// call and jump, each followed by the inserted no-op
		run(14'h2005, 0, 0, SUBROUTINE_CALL, MSK_NONE, 1, 0);
		chk(16'(target_out), 16'h0005);
		run(14'h07a5, 0, 0, NO_OP, MSK_NONE, 0, 1);
		run(14'h2fff, 0, 0, JUMP_DIRECT, MSK_NONE, 1, 0);
		chk(16'(target_out), 16'h07ff);
		run(14'h07a5, 0, 0, NO_OP, MSK_NONE, 0, 1);
		// literal ops, low opcode bits ignored where marked
		run(14'h38a5, 0, 0, INCLUSIVE_OR_LITERAL, MSK_Z, 0, 0);
		chk(16'(literal_out), 16'h00a5);
		run(14'h395a, 0, 0, LOGICAL_AND_LITERAL, MSK_Z, 0, 0);
		run(14'h3aa5, 0, 0, EXCLUSIVE_OR_LITERAL, MSK_Z, 0, 0);
		run(14'h3ca5, 0, 0, SUBTRACT_FROM_LITERAL, MSK_CDZ, 0, 0);
		run(14'h3da5, 0, 0, SUBTRACT_FROM_LITERAL, MSK_CDZ, 0, 0);
		run(14'h3ea5, 0, 0, ADD_LITERAL_ACCUM, MSK_CDZ, 0, 0);
		run(14'h3fa5, 0, 0, ADD_LITERAL_ACCUM, MSK_CDZ, 0, 0);
		run(14'h30a5, 0, 0, LOAD_LITERAL_ACCUM, MSK_NONE, 0, 0);
		run(14'h33a5, 0, 0, LOAD_LITERAL_ACCUM, MSK_NONE, 0, 0);
		run(14'h37a5, 0, 0, RETURN_WITH_LITERAL, MSK_NONE, 1, 0);
		run(14'h07a5, 0, 0, NO_OP, MSK_NONE, 0, 1);
		// returns and power-control words
		run(14'h0008, 0, 0, SUBROUTINE_RETURN, MSK_NONE, 1, 0);
		run(14'h07a5, 0, 0, NO_OP, MSK_NONE, 0, 1);
		run(14'h0009, 0, 0, INTERRUPT_RETURN, MSK_NONE, 1, 0);
		run(14'h07a5, 0, 0, NO_OP, MSK_NONE, 0, 1);
		run(14'h0064, 0, 0, WATCHDOG_CLEAR_OP, MSK_TS, 0, 0);
		run(14'h0063, 0, 0, STANDBY_ENTER_OP, MSK_TS, 0, 0);
		// prescaler clear: only with prescaler assigned, file write-back
		reg_wr(REG_CTRL, 8'h01);
		reg_rd(REG_CTRL, 8'h01);
		run(14'h0a81, 0, 0, INCREMENT_OP, MSK_Z, 0, 0);
		chk(16'(prescaler_clr_out), 16'h0001);
		run(14'h0a01, 0, 0, INCREMENT_OP, MSK_Z, 0, 0);
		chk(16'(prescaler_clr_out), 16'h0000);
		run(14'h1001, 0, 0, BIT_CLEAR_OP, MSK_NONE, 0, 0);
		chk(16'(prescaler_clr_out), 16'h0001);
		run(14'h1801, 0, 1, BIT_TEST_SKIP_CLEAR, MSK_NONE, 0, 0);
		chk(16'(prescaler_clr_out), 16'h0000);
		reg_wr(REG_CTRL, 8'h00);
		run(14'h0a81, 0, 0, INCREMENT_OP, MSK_Z, 0, 0);
		chk(16'(prescaler_clr_out), 16'h0000);
		// port self-modify reads pins; a plain clear does not
		run(14'h0885, 0, 0, MOVE_FILE_OP, MSK_Z, 0, 0);
		chk(16'(pin_read_out), 16'h0001);
		run(14'h0805, 0, 0, MOVE_FILE_OP, MSK_Z, 0, 0);
		chk(16'(pin_read_out), 16'h0000);
		run(14'h0185, 0, 0, CLEAR_OP, MSK_Z, 0, 0);
		chk(16'(pin_read_out), 16'h0000);
		run(14'h1405, 0, 0, BIT_SET_OP, MSK_NONE, 0, 0);
		chk(16'(pin_read_out), 16'h0001);
		// four skips were taken above; status shows them in bits 7:2
		reg_rd(REG_STAT, 8'h10);
		// reset in mid-cycle: first quarter again, then a clean decode
		@(posedge clk_in);
		rst_in <= 1'b1;
		instr_in <= 14'h0000;
		@(posedge clk_in);
		rst_in <= 1'b0;
		instr_in <= 14'h2005;
		#1;
		chk(16'(op_out), 16'(NO_OP));
		chk(16'(phase_out), 16'h0000);
		@(posedge clk_in);
		#1;
		chk(16'(op_out), 16'(SUBROUTINE_CALL));
		chk(16'(phase_out), 16'h0001);
		results();
	end
endmodule
